// >>> shared/sync_edge_pkg.sv
package sync_edge_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] OFS_SYNC_EDGE_SENSE = 8'h00;
   localparam logic [7:0] OFS_INT_STATUS = 8'h01;
   localparam logic [7:0] OFS_INT_MASK = 8'h02;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int BIT_VERT_SYNC_EDGE = 7;
   localparam int BIT_HORIZ_SYNC_EDGE = 6;
   localparam int BIT_COMPOSITE_SYNC_EDGE = 5;
   localparam int BIT_HORIZ_FLYBACK_EDGE = 4;
   localparam int BIT_VERT_FLYBACK_EDGE = 3;
   localparam int BIT_PRE_EQUALIZATION = 2;
   localparam int BIT_HORIZ_LEVEL = 1;
   localparam int BIT_VERT_LEVEL = 0;
   localparam int FLAG_LSB = 2;
   localparam int NUM_FLAGS = 6;
   localparam int NUM_PINS = 5;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [5:0] FLAGS_RESET = 6'h00;
   localparam logic [5:0] INT_STATUS_RESET = 6'h00;
   localparam logic [5:0] INT_MASK_RESET = 6'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam int SYNC_STAGES_DEFAULT = 2;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   // field order follows flag bits 7 down to 3
   typedef struct packed {
      logic vert_sync_in_pin;
      logic horiz_sync_in_pin;
      logic composite_sync_in_pin;
      logic horiz_flyback_in_pin;
      logic vert_flyback_in_pin;
   } sync_pins_t;

   typedef struct packed {
      logic internal_horiz_sync;
      logic internal_vert_sync;
      logic mask_interval;
   } internal_sync_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage : sync_edge_pkg

// >>> src/pin_sync.sv
`timescale 1ns/100ps

module pin_sync #(
   parameter int WIDTH = 5,
   parameter int STAGES = 2
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   if (STAGES < 2) begin : g_bad_stages
      $error("pin_sync needs at least two stages");
   end

   logic [WIDTH-1:0] stage_reg [STAGES];

   // first stage feeds only the second
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < STAGES; i++) begin
            stage_reg[i] <= '0;
         end
      end else begin
         stage_reg[0] <= async_in;
         for (int i = 1; i < STAGES; i++) begin
            stage_reg[i] <= stage_reg[i-1];
         end
      end
   end

   assign sync_out = stage_reg[STAGES-1];

endmodule : pin_sync

// >>> src/edge_flag_cell.sv
`timescale 1ns/100ps

module edge_flag_cell (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // events
   input wire logic set_event,
   input wire logic read_one,
   input wire logic write_zero,
   input wire logic write_any,
   // state
   output logic flag
);

   logic armed_reg;

   // a read that saw 1 arms the clear; any write uses it up
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         armed_reg <= 1'b0;
      end else if (write_any) begin
         armed_reg <= 1'b0;
      end else if (read_one) begin
         armed_reg <= 1'b1;
      end
   end

   // set wins over a clearing write in the same cycle
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         flag <= 1'b0;
      end else if (set_event) begin
         flag <= 1'b1;
      end else if (write_zero && armed_reg) begin
         flag <= 1'b0;
      end
   end

endmodule : edge_flag_cell

// >>> src/sync_edge_sense_flags.sv
`timescale 1ns/100ps

//
// Function
// - a rising edge on the vertical sync input pin sets flag bit 7, cleared by writing 0 after reading 1.
// - a rising edge on the horizontal sync input pin sets flag bit 6, cleared the same way.
// - a rising edge on the composite sync input pin sets flag bit 5, cleared the same way.
// - a rising edge on the horizontal flyback input pin sets flag bit 4, cleared the same way.
// - a rising edge on the vertical flyback input pin sets flag bit 3, cleared the same way.
// - any edge of the internal horizontal sync inside the mask interval sets the pre-equalization flag, bit 2.
// - the pre-equalization flag clears only on a write of 0 following a read that returned it as 1.
// - software may only clear flag bits with 0; writing 1 never sets them.
// - bit 1 reads the live internal horizontal sync level and ignores writes.
// - bit 0 reads the live internal vertical sync level and ignores writes.
// - the two level bits have no reset value and follow the signals from reset on.
// - the level bits show the internal signals after source selection and inversion.
//

module sync_edge_sense_flags #(
   parameter int NUM_SYNC_STAGES = sync_edge_pkg::SYNC_STAGES_DEFAULT
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // register port
   input wire sync_edge_pkg::reg_req_t bus_req,
   output logic [sync_edge_pkg::DATA_W-1:0] rdata,
   // sync and flyback pins
   input wire sync_edge_pkg::sync_pins_t pins,
   // internal sync after selection and inversion
   input wire sync_edge_pkg::internal_sync_t internal,
   // interrupt
   output logic irq
);

   if (NUM_SYNC_STAGES < 2 || NUM_SYNC_STAGES > 15) begin : g_bad_stages
      $error("NUM_SYNC_STAGES must lie in 2..15");
   end

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   function automatic logic hit(
      input logic [sync_edge_pkg::ADDR_W-1:0] addr,
      input logic [sync_edge_pkg::ADDR_W-1:0] ofs
   );
      hit = (addr == ofs);
   endfunction : hit

   logic rd_sense;
   logic wr_sense;
   logic wr_status;
   logic wr_mask;

   assign rd_sense = bus_req.rd && hit(bus_req.addr, sync_edge_pkg::OFS_SYNC_EDGE_SENSE);
   assign wr_sense = bus_req.wr && hit(bus_req.addr, sync_edge_pkg::OFS_SYNC_EDGE_SENSE);
   assign wr_status = bus_req.wr && hit(bus_req.addr, sync_edge_pkg::OFS_INT_STATUS);
   assign wr_mask = bus_req.wr && hit(bus_req.addr, sync_edge_pkg::OFS_INT_MASK);

   // ------------------------------------------------------------
   // pin synchronisers and edge detection
   // ------------------------------------------------------------
   logic [sync_edge_pkg::NUM_PINS-1:0] pins_sync;
   logic [sync_edge_pkg::NUM_PINS-1:0] pins_prev_reg;
   logic [sync_edge_pkg::NUM_PINS-1:0] pin_rise;
   logic [3:0] settle_reg;
   logic settled;

   pin_sync #(
      .WIDTH(sync_edge_pkg::NUM_PINS),
      .STAGES(NUM_SYNC_STAGES)
   ) u_pin_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .async_in(pins),
      .sync_out(pins_sync)
   );

   // synchroniser comes out of reset low; the count opens edge detection as the first real sample reaches pins_sync,
   // with pins_prev_reg still low, so a pin held high still looks like a rising edge when the count completes
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         settle_reg <= 4'h0;
      end else if (!settled) begin
         settle_reg <= settle_reg + 4'h1;
      end
   end

   assign settled = (settle_reg == 4'(NUM_SYNC_STAGES));

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pins_prev_reg <= '0;
      end else begin
         pins_prev_reg <= pins_sync;
      end
   end

   assign pin_rise = settled ? (pins_sync & ~pins_prev_reg) : '0;

   // ------------------------------------------------------------
   // double-rate line modification detection
   // ------------------------------------------------------------
   logic ihs_prev_reg;
   logic pre_eq_event;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ihs_prev_reg <= 1'b0;
      end else begin
         ihs_prev_reg <= internal.internal_horiz_sync;
      end
   end

   // either edge counts, but only while the mask interval is open
   assign pre_eq_event = settled && internal.mask_interval &&
                         (internal.internal_horiz_sync != ihs_prev_reg);

   // ------------------------------------------------------------
   // sticky flags, bits 7 down to 2
   // ------------------------------------------------------------
   logic [sync_edge_pkg::NUM_FLAGS-1:0] set_events;
   logic [sync_edge_pkg::NUM_FLAGS-1:0] flags;
   logic [sync_edge_pkg::DATA_W-1:0] sense_value;

   // pin bits land on 7..3 in struct order, pre-equalization on 2
   assign set_events = {pin_rise, pre_eq_event};

   for (genvar i = 0; i < sync_edge_pkg::NUM_FLAGS; i++) begin : g_flag
      edge_flag_cell u_cell (
         .sys_clk(sys_clk),
         .reset(reset),
         .set_event(set_events[i]),
         .read_one(rd_sense && flags[i]),
         .write_zero(wr_sense && !bus_req.wdata[sync_edge_pkg::FLAG_LSB+i]),
         .write_any(wr_sense),
         .flag(flags[i])
      );
   end

   // level bits are never stored, so writes cannot reach them
   assign sense_value = {flags, internal.internal_horiz_sync, internal.internal_vert_sync};

   // ------------------------------------------------------------
   // interrupt status and mask
   // ------------------------------------------------------------
   logic [5:0] int_status_reg;
   logic [5:0] int_status_next;
   logic [5:0] int_mask_reg;
   logic [5:0] int_mask_next;

   always_comb begin
      int_status_next = int_status_reg;
      if (wr_status) begin
         int_status_next = int_status_next & ~bus_req.wdata[7:2];
      end
      int_status_next = int_status_next | set_events;
   end

   always_comb begin
      int_mask_next = int_mask_reg;
      if (wr_mask) begin
         int_mask_next = bus_req.wdata[7:2];
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         int_status_reg <= sync_edge_pkg::INT_STATUS_RESET;
      end else begin
         int_status_reg <= int_status_next;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         int_mask_reg <= sync_edge_pkg::INT_MASK_RESET;
      end else begin
         int_mask_reg <= int_mask_next;
      end
   end

   // built from next values so the pin tracks the registers with no lag
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_status_next & int_mask_next);
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rdata <= sync_edge_pkg::RDATA_RESET;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            sync_edge_pkg::OFS_SYNC_EDGE_SENSE: begin
               rdata <= sense_value;
            end
            sync_edge_pkg::OFS_INT_STATUS: begin
               rdata <= {int_status_reg, 2'h0};
            end
            sync_edge_pkg::OFS_INT_MASK: begin
               rdata <= {int_mask_reg, 2'h0};
            end
            default: begin
               rdata <= 8'h00;
            end
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   // set by a read of the sense register, dropped by any write to it
   logic sense_read_seen_reg;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sense_read_seen_reg <= 1'b0;
      end else if (wr_sense) begin
         sense_read_seen_reg <= 1'b0;
      end else if (rd_sense) begin
         sense_read_seen_reg <= 1'b1;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking

   default disable iff (reset);

   a_vert_edge_set: assert property (
      settled && pins_sync[4] && !pins_prev_reg[4] |=> flags[5] && int_status_reg[5]
   ) else $error("vertical sync edge did not set its flag");

   a_horiz_edge_set: assert property (
      settled && pins_sync[3] && !pins_prev_reg[3] |=> flags[4]
   ) else $error("horizontal sync edge did not set its flag");

   a_comp_edge_set: assert property (
      settled && pins_sync[2] && !pins_prev_reg[2] |=> flags[3]
   ) else $error("composite sync edge did not set its flag");

   a_hfly_edge_set: assert property (
      settled && pins_sync[1] && !pins_prev_reg[1] |=> flags[2]
   ) else $error("horizontal flyback edge did not set its flag");

   a_vfly_edge_set: assert property (
      settled && pins_sync[0] && !pins_prev_reg[0] |=> flags[1]
   ) else $error("vertical flyback edge did not set its flag");

   a_pre_eq_set: assert property (
      settled && internal.mask_interval && $changed(internal.internal_horiz_sync) |=> flags[0]
   ) else $error("sync edge in mask interval did not set pre-equalization flag");

   a_no_edge_hold: assert property (
      !internal.mask_interval && set_events[0] == 1'b0 && !wr_sense |=> flags[0] == $past(flags[0])
   ) else $error("pre-equalization flag changed without cause");

   a_fall_needs_write: assert property (
      $fell(flags[0]) |-> $past(wr_sense && !bus_req.wdata[2])
   ) else $error("pre-equalization flag cleared without a zero write");

   a_read_then_clear: assert property (
      rd_sense && set_events == 6'h00 ##1 wr_sense && bus_req.wdata[7:2] == 6'h00 && set_events == 6'h00
      |=> flags == 6'h00
   ) else $error("read of one then zero write did not clear flags");

   a_clear_without_read: assert property (
      wr_sense && !sense_read_seen_reg && bus_req.wdata[7:2] == 6'h00
      |=> flags == ($past(flags) | $past(set_events))
   ) else $error("zero write cleared a flag that was not read as one");

   a_one_write_keeps: assert property (
      wr_sense && bus_req.wdata[7:2] == 6'h3f && set_events == 6'h00 |=> flags == $past(flags)
   ) else $error("writing one changed a flag");

   a_level_bits_read: assert property (
      rd_sense |=> rdata[1:0] == $past({internal.internal_horiz_sync, internal.internal_vert_sync})
   ) else $error("level bits do not follow internal sync");

   a_set_beats_clear: assert property (
      set_events[5] && wr_sense && !bus_req.wdata[7] |=> flags[5]
   ) else $error("clearing write beat a set event");

   a_flags_reset: assert property (
      @(posedge sys_clk) disable iff (1'b0) reset |-> flags == sync_edge_pkg::FLAGS_RESET
   ) else $error("flags not zero during reset");

   a_irq_level: assert property (
      irq == |(int_status_reg & int_mask_reg)
   ) else $error("interrupt output disagrees with status and mask");

   a_rdata_idle: assert property (
      !$past(bus_req.rd) |-> rdata == 8'h00
   ) else $error("read data not zero outside the read answer cycle");

   a_flag_rise_cause: assert property (
      (flags & ~$past(flags) & ~$past(set_events)) == 6'h00
   ) else $error("flag rose without a set event");

   a_status_follows: assert property (
      set_events != 6'h00 |=> (int_status_reg & $past(set_events)) == $past(set_events)
   ) else $error("event did not reach interrupt status");

   a_status_w1c: assert property (
      wr_status |=> int_status_reg == (($past(int_status_reg) & ~$past(bus_req.wdata[7:2])) | $past(set_events))
   ) else $error("status write did not clear the written ones");

   a_mask_write: assert property (
      wr_mask |=> int_mask_reg == $past(bus_req.wdata[7:2])
   ) else $error("mask write did not land");

   a_unmapped_read: assert property (
      bus_req.rd && bus_req.addr > sync_edge_pkg::OFS_INT_MASK |=> rdata == 8'h00
   ) else $error("unmapped read returned nonzero data");

   c_clear_refused: cover property (
      wr_sense && !sense_read_seen_reg && flags != 6'h00
   );

   c_flag_cycle: cover property (
      flags[5] ##1 rd_sense ##1 (wr_sense && !bus_req.wdata[7]) ##1 !flags[5]
   );

   c_pre_eq: cover property (
      pre_eq_event ##1 flags[0]
   );

   c_irq_rise: cover property (
      $rose(irq)
   );

   c_set_and_clear: cover property (
      set_events[4] && wr_sense && !bus_req.wdata[6]
   );

endmodule : sync_edge_sense_flags

// >>> verif/sync_source_model.sv
`timescale 1ns/100ps

module sync_source_model (
   // clock
   input wire logic sys_clk,
   // requests from the bench
   input wire logic [4:0] pulse_req,
   input wire logic ihs_raw,
   input wire logic ivs_raw,
   input wire logic mask_req,
   input wire logic [1:0] invert,
   // towards the block
   output sync_edge_pkg::sync_pins_t pins,
   output sync_edge_pkg::internal_sync_t internal
);
   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   // no reset: sources outside the device keep running through it
   always_ff @(posedge sys_clk) begin
      pins <= pulse_req;
   end

   // ------------------------------------------------------------
   // internal sync after selection and inversion
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      internal.internal_horiz_sync <= ihs_raw ^ invert[1];
      internal.internal_vert_sync <= ivs_raw ^ invert[0];
      internal.mask_interval <= mask_req;
   end
endmodule : sync_source_model

// >>> verif/sync_edge_sense_flags_test.sv
`timescale 1ns/100ps

module sync_edge_sense_flags_test;
   logic sys_clk = 1'b0;
   logic reset;
   sync_edge_pkg::reg_req_t req = '0;
   logic [7:0] rdata;
   logic irq;
   sync_edge_pkg::sync_pins_t pins;
   sync_edge_pkg::internal_sync_t internal;
   logic [4:0] pulse_req = 5'h00;
   logic ihs_raw = 1'b0;
   logic ivs_raw = 1'b0;
   logic mask_req = 1'b0;
   logic [1:0] invert = 2'h0;
   logic [31:0] seed = 32'he78fc031;
   logic [7:0] d;
   logic [4:0] m;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;

   initial begin
      forever #10 sys_clk = ~sys_clk;
   end

   sync_edge_sense_flags u_sync_edge_sense_flags (.sys_clk(sys_clk), .reset(reset), .bus_req(req),
      .rdata(rdata), .pins(pins), .internal(internal), .irq(irq));

   sync_source_model u_sync_source_model (.sys_clk(sys_clk), .pulse_req(pulse_req), .ihs_raw(ihs_raw),
      .ivs_raw(ivs_raw), .mask_req(mask_req), .invert(invert), .pins(pins), .internal(internal));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   // levels are worked out from what the bench asked the sources for
   function automatic logic [7:0] sense(input logic [5:0] f);
      return {f, ihs_raw ^ invert[1], ivs_raw ^ invert[0]};
   endfunction : sense

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      req <= '0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req <= '0;
      #1;
      v = rdata;
   endtask : rd

   // read of the sense register, then a zero write with no idle cycle
   task automatic rd_clr(output logic [7:0] v);
      @(posedge sys_clk);
      req <= '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req <= '{addr: 8'h00, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
      #1;
      v = rdata;
      @(posedge sys_clk);
      req <= '0;
      #1;
   endtask : rd_clr

   // one-cycle pulse, then the pin stays low for several samples
   task automatic pulse(input logic [4:0] p);
      @(posedge sys_clk);
      pulse_req <= p;
      @(posedge sys_clk);
      pulse_req <= 5'h00;
      repeat (6) @(posedge sys_clk);
      #1;
   endtask : pulse

   task automatic done(input string name);
      $display("test %s finished, %0d mismatches so far", name, bad_count);
   endtask : done

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test

   // ------------------------------------------------------------
   // hang guard
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         finish_test();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      // driven at time zero so the design sees a reset edge
      reset <= 1'b1;
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rd(8'h00, d); check("sense after reset", d, sense(6'h00));
      rd(8'h01, d); check("status after reset", d, 8'h00);
      rd(8'h02, d); check("mask after reset", d, 8'h00);
      rd(8'h05, d); check("unmapped read", d, 8'h00);
      done("reset");

      // idle-high sync is negative phase; software inverts it
      ihs_raw <= 1'b1;
      rd(8'h00, d); check("raw horiz level", d, 8'h02);
      if (d[1] === 1'b1) invert <= 2'h2;
      rd(8'h00, d); check("inverted level", d, sense(6'h00));
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         ihs_raw <= seed[0];
         ivs_raw <= seed[1];
         wr(8'h00, 8'h03);
         rd(8'h00, d); check("live levels", d, sense(6'h00));
      end
      done("levels");

      for (int i = 0; i < 5; i++) begin
         m = 5'h10 >> i;
         pulse(m);
         rd(8'h00, d); check("edge flag set", d, sense({m, 1'b0}));
         wr(8'h00, 8'hff);
         wr(8'h00, 8'h00);
         rd(8'h00, d); check("clear without read", d, sense({m, 1'b0}));
         wr(8'h00, 8'h00);
         rd(8'h00, d); check("edge flag cleared", d, sense(6'h00));
         check("irq masked off", {7'h00, irq}, 8'h00);
      end
      wr(8'h00, 8'hff);
      rd(8'h00, d); check("write ones", d, sense(6'h00));
      wr(8'h01, 8'hfc);
      done("pins");

      for (int j = 0; j < 2; j++) begin
         mask_req <= 1'b1;
         @(posedge sys_clk);
         ihs_raw <= ~ihs_raw;
         repeat (3) @(posedge sys_clk);
         mask_req <= 1'b0;
         rd(8'h00, d); check("pre-eq set", d, sense(6'h01));
         wr(8'h00, 8'h00);
         rd(8'h00, d); check("pre-eq cleared", d, sense(6'h00));
         ihs_raw <= ~ihs_raw;
         repeat (3) @(posedge sys_clk);
         rd(8'h00, d); check("edge outside mask", d, sense(6'h00));
      end
      wr(8'h01, 8'hfc);
      done("pre-equalization");

      wr(8'h02, 8'hfc);
      pulse(5'h01);
      check("irq raised", {7'h00, irq}, 8'h01);
      rd(8'h01, d); check("status bit", d, 8'h08);
      wr(8'h02, 8'h00);
      @(posedge sys_clk); #1;
      check("irq masked", {7'h00, irq}, 8'h00);
      wr(8'h02, 8'hfc);
      @(posedge sys_clk); #1;
      check("irq unmasked", {7'h00, irq}, 8'h01);
      wr(8'h01, 8'h08);
      @(posedge sys_clk); #1;
      check("irq cleared", {7'h00, irq}, 8'h00);
      rd(8'h00, d); check("flag kept", d, sense(6'h02));
      wr(8'h00, 8'h00);
      wr(8'h02, 8'h00);
      done("interrupt");

      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         m = seed[4:0];
         ivs_raw <= seed[7];
         pulse(m);
         rd_clr(d); check("random edges", d, sense({m, 1'b0}));
         rd(8'h00, d); check("random clear", d, sense(6'h00));
      end
      done("random");

      pulse(5'h1f);
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rd(8'h00, d); check("flags after reset", d, sense(6'h00));
      rd(8'h01, d); check("status after reset", d, 8'h00);
      done("second reset");
      finish_test();
   end
endmodule : sync_edge_sense_flags_test
